// file: core/touch_screen_adc_control.v
`include "touch_adc_map.vh"

module touch_screen_adc_control #(
  parameter RESULT_BITS = 10,
  parameter [5:0] VERSION_CODE = 6'h15, // value is arbitrary
  parameter [5:0] DEVICE_CODE = 6'h2a, // value is arbitrary
  parameter [3:0] VENDOR_CODE = 4'h5 // value is arbitrary
) (
  input wire mclk,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  input wire sync_strobe,
  input wire plus_x_plate_pin,
  input wire minus_x_plate_pin,
  input wire comparator_above,
  output wire minus_x_power,
  output wire plus_x_power,
  output wire minus_y_power,
  output wire plus_y_power,
  output wire minus_x_ground,
  output wire plus_x_ground,
  output wire minus_y_ground,
  output wire plus_y_ground,
  output wire [1:0] touch_operation_mode,
  output wire touch_interrupt_mode,
  output wire touch_pressure_mode,
  output wire touch_position_mode,
  output wire touch_bias_enable,
  output wire converter_sync_enable,
  output wire reference_to_bypass_pin,
  output wire external_reference_select,
  output wire converter_enable,
  output reg [2:0] input_select,
  output wire [RESULT_BITS-1:0] trial_code,
  output wire sample_hold,
  output wire conversion_busy
);

  localparam integer TRACK_CYCLES =
    (`TRACK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer SETTLE_RAW =
    (`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;

  reg [15:0] touch_reg;
  reg [15:0] adc_ctrl_reg;
  reg [RESULT_BITS-1:0] result_reg;
  reg done_flag_reg;
  reg start_prev_reg;
  reg start_pending_reg;

  wire [2:0] pins_sync;
  wire [3:0] plate_ground;
  wire [3:0] plate_power;
  wire plus_x_level;
  wire minus_x_level;
  wire comp_sync;

  wire wr_touch;
  wire wr_adc_ctrl;
  wire [15:0] adc_ctrl_next;
  wire start_rise;
  wire launch;
  wire abort;
  wire sar_done;
  wire [RESULT_BITS-1:0] sar_result;
  wire [15:0] touch_read;
  wire [15:0] result_read;
  wire [15:0] id_read;
  reg [15:0] rdata_next;

  // pins come from the analog side: two flops before any use
  // plates idle high, so the synchroniser resets to pen up
  level_sync #(
    .WIDTH(3),
    .RESET_LEVEL(3'b011)
  ) u_pin_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({comparator_above, minus_x_plate_pin, plus_x_plate_pin}),
    .sync_out(pins_sync)
  );
  assign plus_x_level = pins_sync[0];
  assign minus_x_level = pins_sync[1];
  assign comp_sync = pins_sync[2];

  assign wr_touch = reg_write && (reg_addr == `ADDR_TOUCH_PANEL_CONTROL);
  assign wr_adc_ctrl = reg_write && (reg_addr == `ADDR_ADC_CONTROL);
  assign adc_ctrl_next = reg_wdata & `AC_WRITE_MASK;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      touch_reg <= `TP_RESET;
    end else if (wr_touch) begin
      touch_reg <= reg_wdata & `TP_WRITE_MASK;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      adc_ctrl_reg <= `AC_RESET;
    end else if (wr_adc_ctrl) begin
      adc_ctrl_reg <= adc_ctrl_next;
    end
  end

  // plate order in both fields: minus x, plus x, minus y, plus y
  assign plate_ground =
    touch_reg[`TP_PLUS_Y_GROUND:`TP_MINUS_X_GROUND];

  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_plate
      // ground wins so a plate is never shorted supply to ground
      assign plate_power[p] = touch_reg[`TP_MINUS_X_POWER + p] &
        ~plate_ground[p];
    end
  endgenerate

  assign minus_x_ground = plate_ground[0];
  assign plus_x_ground = plate_ground[1];
  assign minus_y_ground = plate_ground[2];
  assign plus_y_ground = plate_ground[3];
  assign minus_x_power = plate_power[0];
  assign plus_x_power = plate_power[1];
  assign minus_y_power = plate_power[2];
  assign plus_y_power = plate_power[3];

  assign touch_operation_mode = touch_reg[`TP_MODE_HI:`TP_MODE_LO];
  assign touch_interrupt_mode =
    (touch_operation_mode == `MODE_INTERRUPT);
  assign touch_pressure_mode =
    (touch_operation_mode == `MODE_PRESSURE);
  assign touch_position_mode = touch_operation_mode[1];
  assign touch_bias_enable = touch_reg[`TP_BIAS_ENABLE];

  assign converter_sync_enable = adc_ctrl_reg[`AC_SYNC_ENABLE];
  assign reference_to_bypass_pin =
    adc_ctrl_reg[`AC_REF_TO_BYPASS];
  assign external_reference_select =
    adc_ctrl_reg[`AC_EXT_REF_SELECT];
  assign converter_enable = adc_ctrl_reg[`AC_CONVERTER_ENABLE];

  // start edge is taken from the stored bit, so a rewrite of one is no edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= adc_ctrl_reg[`AC_START];
    end
  end
  assign start_rise = adc_ctrl_reg[`AC_START] & ~start_prev_reg;

  // a disabled converter drops any conversion in flight
  assign abort = ~converter_enable;

  // in sync mode the edge arms a request that waits for the sync strobe
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start_pending_reg <= 1'b0;
    end else if (abort || launch) begin
      start_pending_reg <= 1'b0;
    end else if (start_rise) begin
      start_pending_reg <= 1'b1;
    end
  end

  assign launch = converter_enable && !conversion_busy &&
    (converter_sync_enable ? (start_pending_reg && sync_strobe)
                           : start_pending_reg);

  // input code is frozen for the whole conversion
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      input_select <= 3'h0;
    end else if (launch) begin
      input_select <= adc_ctrl_reg[`AC_SELECT_HI:`AC_SELECT_LO];
    end
  end

  sar_engine #(
    .BITS(RESULT_BITS),
    .TRACK_CYCLES(TRACK_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_sar (
    .mclk(mclk),
    .rstn(rstn),
    .start(launch),
    .abort(abort),
    .comp_above(comp_sync),
    .trial_code(trial_code),
    .hold(sample_hold),
    .busy(conversion_busy),
    .done(sar_done),
    .result(sar_result)
  );

  // flag low from the start until the result is stored
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= `AR_RESULT_RESET;
      done_flag_reg <= 1'b0;
    end else if (sar_done) begin
      result_reg <= sar_result;
      done_flag_reg <= 1'b1;
    end else if (launch || start_rise) begin
      done_flag_reg <= 1'b0;
    end
  end

  assign touch_read = {2'b00,
    ~minus_x_level, ~plus_x_level,
    touch_reg[11:0]};
  assign result_read = {done_flag_reg, result_reg, 5'h00};
  assign id_read = {VENDOR_CODE, DEVICE_CODE, VERSION_CODE};

  always @* begin
    if (reg_addr == `ADDR_TOUCH_PANEL_CONTROL) begin
      rdata_next = touch_read;
    end else if (reg_addr == `ADDR_ADC_CONTROL) begin
      rdata_next = adc_ctrl_reg;
    end else if (reg_addr == `ADDR_ADC_RESULT) begin
      rdata_next = result_read;
    end else if (reg_addr == `ADDR_CHIP_IDENTIFICATION) begin
      rdata_next = id_read;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule // touch_screen_adc_control

// file: core/touch_adc_map.vh
`ifndef TOUCH_ADC_MAP_VH
`define TOUCH_ADC_MAP_VH

// register addresses on the device register port
`define ADDR_TOUCH_PANEL_CONTROL 4'h9
`define ADDR_ADC_CONTROL 4'ha
`define ADDR_ADC_RESULT 4'hb
`define ADDR_CHIP_IDENTIFICATION 4'hc

// touch_panel_control fields
`define TP_MINUS_X_POWER 0
`define TP_PLUS_X_POWER 1
`define TP_MINUS_Y_POWER 2
`define TP_PLUS_Y_POWER 3
`define TP_MINUS_X_GROUND 4
`define TP_PLUS_X_GROUND 5
`define TP_MINUS_Y_GROUND 6
`define TP_PLUS_Y_GROUND 7
`define TP_MODE_LO 8
`define TP_MODE_HI 9
`define TP_BIAS_ENABLE 11
`define TP_PLUS_X_PEN_DOWN 12
`define TP_MINUS_X_PEN_DOWN 13
`define TP_WRITE_MASK 16'h0bff
`define TP_RESET 16'h0000

// touch operation modes
`define MODE_INTERRUPT 2'h0
`define MODE_PRESSURE 2'h1

// adc_control fields
`define AC_SYNC_ENABLE 0
`define AC_REF_TO_BYPASS 1
`define AC_SELECT_LO 2
`define AC_SELECT_HI 4
`define AC_EXT_REF_SELECT 5
`define AC_START 7
`define AC_CONVERTER_ENABLE 15
`define AC_WRITE_MASK 16'h80bf
`define AC_RESET 16'h0000

// adc_result fields
`define AR_DATA_LO 5
`define AR_DATA_HI 14
`define AR_DONE_FLAG 15
`define AR_RESULT_RESET 10'h000

// chip_identification fields
`define ID_VERSION_LO 0
`define ID_VERSION_HI 5
`define ID_DEVICE_LO 6
`define ID_DEVICE_HI 11
`define ID_VENDOR_LO 12
`define ID_VENDOR_HI 15

// timing
`define CLK_PERIOD_NS 8
`define TRACK_TIME_NS 1000
`define SETTLE_TIME_NS 40

`endif

// file: core/level_sync.v
module level_sync #(
  parameter WIDTH = 1,
  // per-bit reset level; match the idle level of the pin to avoid a false edge
  parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rstn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg first_reg;
      reg second_reg;
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          first_reg <= RESET_LEVEL[i];
          second_reg <= RESET_LEVEL[i];
        end else begin
          first_reg <= async_in[i];
          second_reg <= first_reg;
        end
      end
      assign sync_out[i] = second_reg;
    end
  endgenerate

endmodule // level_sync

// file: core/sar_engine.v
module sar_engine #(
  parameter BITS = 10,
  parameter TRACK_CYCLES = 125,
  parameter SETTLE_CYCLES = 5
) (
  input wire mclk,
  input wire rstn,
  input wire start,
  input wire abort,
  input wire comp_above,
  output wire [BITS-1:0] trial_code,
  output wire hold,
  output wire busy,
  output reg done,
  output reg [BITS-1:0] result
);

  localparam S_IDLE = 2'd0;
  localparam S_TRACK = 2'd1;
  localparam S_SETTLE = 2'd2;
  localparam S_DECIDE = 2'd3;

  reg [1:0] state_reg;
  reg [15:0] count_reg;
  reg [BITS-1:0] acc_reg;
  reg [BITS-1:0] mask_reg;

  assign trial_code = acc_reg | mask_reg;
  assign hold = (state_reg == S_SETTLE) || (state_reg == S_DECIDE);
  assign busy = (state_reg != S_IDLE);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      count_reg <= 16'h0000;
      acc_reg <= {BITS{1'b0}};
      mask_reg <= {BITS{1'b0}};
      done <= 1'b0;
      result <= {BITS{1'b0}};
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_reg <= S_IDLE;
        mask_reg <= {BITS{1'b0}};
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (start) begin
              state_reg <= S_TRACK;
              count_reg <= 16'h0000;
              acc_reg <= {BITS{1'b0}};
              mask_reg <= {BITS{1'b0}};
            end
          end
          S_TRACK: begin
            if (count_reg == TRACK_CYCLES - 1) begin
              state_reg <= S_SETTLE;
              count_reg <= 16'h0000;
              mask_reg <= {1'b1, {(BITS-1){1'b0}}};
            end else begin
              count_reg <= count_reg + 16'h0001;
            end
          end
          S_SETTLE: begin
            if (count_reg == SETTLE_CYCLES - 1) begin
              state_reg <= S_DECIDE;
              count_reg <= 16'h0000;
            end else begin
              count_reg <= count_reg + 16'h0001;
            end
          end
          default: begin
            // keep the trial bit only when the input sits above it
            if (mask_reg[0]) begin
              state_reg <= S_IDLE;
              done <= 1'b1;
              result <= comp_above ? (acc_reg | mask_reg) : acc_reg;
              mask_reg <= {BITS{1'b0}};
            end else begin
              state_reg <= S_SETTLE;
              mask_reg <= mask_reg >> 1;
            end
            if (comp_above) begin
              acc_reg <= acc_reg | mask_reg;
            end
          end
        endcase
      end
    end
  end

endmodule // sar_engine

// file: tb/panel_model.sv
module panel_model (
  input wire logic [9:0] trial_code,
  input wire logic [9:0] level,
  input wire logic pen_down,
  output logic plus_x_plate_pin,
  output logic minus_x_plate_pin,
  output logic comparator_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-ups hold both plates high with no pen contact
  assign plus_x_plate_pin = ~pen_down;
  assign minus_x_plate_pin = ~pen_down;
  // input sits mid-code, so above and at-or-above agree
  assign comparator_above = {level, 1'b1} > {trial_code, 1'b0};
endmodule // panel_model

// file: tb/touch_adc_properties.sv
`include "touch_adc_map.vh"
module touch_adc_properties #(
  parameter [5:0] VERSION_CODE = 6'h15, // value is arbitrary
  parameter [5:0] DEVICE_CODE = 6'h2a, // value is arbitrary
  parameter [3:0] VENDOR_CODE = 4'h5 // value is arbitrary
) (
  input wire logic mclk, rstn, reg_write, reg_read,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic plus_x_plate_pin, minus_x_plate_pin,
  input wire logic minus_x_ground, plus_x_ground,
  input wire logic minus_y_ground, plus_y_ground,
  input wire logic [1:0] touch_operation_mode,
  input wire logic touch_bias_enable, converter_enable,
  input wire logic conversion_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_tw;
    reg_write && reg_addr == `ADDR_TOUCH_PANEL_CONTROL;
  endsequence
  property p_ground;
    s_tw |=> {plus_y_ground, minus_y_ground, plus_x_ground,
      minus_x_ground} == $past(reg_wdata[7:4]);
  endproperty
  a_ground: assert property (p_ground)
    else $error("ground bits wrong");
  property p_mode;
    s_tw |=> touch_operation_mode == $past(reg_wdata[9:8]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode field wrong");
  property p_bias;
    s_tw |=> touch_bias_enable == $past(reg_wdata[11]);
  endproperty
  a_bias: assert property (p_bias)
    else $error("bias wrong");
  property p_pen;
    $stable({plus_x_plate_pin, minus_x_plate_pin}) [*4] ##0
      (reg_read && reg_addr == `ADDR_TOUCH_PANEL_CONTROL) |=>
      reg_rdata[13:12] == ~$past({minus_x_plate_pin, plus_x_plate_pin});
  endproperty
  a_pen: assert property (p_pen)
    else $error("pen bits wrong");
  property p_idle;
    !converter_enable [*3] |-> !conversion_busy;
  endproperty
  a_idle: assert property (p_idle)
    else $error("busy while disabled");
  property p_launch;
    $rose(conversion_busy) |-> converter_enable;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch while disabled");
  property p_id;
    reg_read && reg_addr == `ADDR_CHIP_IDENTIFICATION |=>
      reg_rdata == {VENDOR_CODE, DEVICE_CODE, VERSION_CODE};
  endproperty
  a_id: assert property (p_id)
    else $error("id wrong");
  property p_flag;
    reg_read && reg_addr == `ADDR_ADC_RESULT && conversion_busy |=>
      !reg_rdata[15];
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag set while busy");
  c_conv: cover property ($fell(conversion_busy) && converter_enable);
  c_abort: cover property ($fell(conversion_busy) && !converter_enable);
  c_pen: cover property (s_tw ##1 !plus_x_plate_pin);
endmodule // touch_adc_properties

bind touch_screen_adc_control touch_adc_properties #(
  .VERSION_CODE(VERSION_CODE), .DEVICE_CODE(DEVICE_CODE),
  .VENDOR_CODE(VENDOR_CODE)
) u_props (
  .mclk, .rstn, .reg_write, .reg_read, .reg_addr, .reg_wdata,
  .reg_rdata, .plus_x_plate_pin, .minus_x_plate_pin, .minus_x_ground,
  .plus_x_ground, .minus_y_ground, .plus_y_ground, .touch_operation_mode,
  .touch_bias_enable, .converter_enable, .conversion_busy
);

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // identification values are arbitrary
  localparam [5:0] VER = 6'h0c;
  localparam [5:0] DEV = 6'h31;
  localparam [3:0] VEN = 4'h9;
  logic mclk = 0, rstn = 0, reg_write = 0, reg_read = 0;
  logic sync_strobe = 0, pen_down = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, w;
  logic [9:0] level = 10'h000, res = 10'h000;
  wire [15:0] reg_rdata;
  wire [1:0] touch_operation_mode;
  wire [2:0] input_select;
  wire [9:0] trial_code;
  wire plus_x_plate_pin, minus_x_plate_pin, comparator_above;
  wire minus_x_power, plus_x_power, minus_y_power, plus_y_power;
  wire minus_x_ground, plus_x_ground, minus_y_ground, plus_y_ground;
  wire touch_interrupt_mode, touch_pressure_mode, touch_position_mode;
  wire touch_bias_enable, converter_sync_enable, reference_to_bypass_pin;
  wire external_reference_select, converter_enable;
  wire sample_hold, conversion_busy;
  int err_count = 0, n_tests = 0, cycles = 0, i;
  int busy_n = 0, hold_n = 0;

  touch_screen_adc_control #(.VERSION_CODE(VER), .DEVICE_CODE(DEV),
    .VENDOR_CODE(VEN)) dut (.mclk, .rstn, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .sync_strobe, .plus_x_plate_pin,
    .minus_x_plate_pin, .comparator_above, .minus_x_power, .plus_x_power,
    .minus_y_power, .plus_y_power, .minus_x_ground, .plus_x_ground,
    .minus_y_ground, .plus_y_ground, .touch_operation_mode,
    .touch_interrupt_mode, .touch_pressure_mode, .touch_position_mode,
    .touch_bias_enable, .converter_sync_enable, .reference_to_bypass_pin,
    .external_reference_select, .converter_enable, .input_select,
    .trial_code, .sample_hold, .conversion_busy);
  panel_model pm (.trial_code, .level, .pen_down, .plus_x_plate_pin,
    .minus_x_plate_pin, .comparator_above);

  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      test_done();
    end
  end
  // counted on the falling edge, where busy and hold have settled
  always @(negedge mclk) begin
    if (conversion_busy) busy_n++;
    if (sample_hold) hold_n++;
  end

  task test_done();
    $display("compares=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task tick();
    @(posedge mclk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    tick();
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    tick();
    reg_write = 0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    tick();
    reg_addr = a;
    reg_read = 1;
    tick();
    reg_read = 0;
    chk(reg_rdata, e);
  endtask
  task wt(input logic want, input int lim);
    for (int k = 0; k < lim && conversion_busy !== want; k++) tick();
    chk({15'h0, conversion_busy}, {15'h0, want});
  endtask
  task conv(input logic [15:0] ctl, input logic [9:0] lv);
    level = lv;
    busy_n = 0;
    hold_n = 0;
    wr(4'ha, ctl & 16'hff7f);
    wr(4'ha, ctl | 16'h0080);
    if (ctl[0]) begin
      repeat (5) tick();
      chk({15'h0, conversion_busy}, 16'h0000);
      sync_strobe = 1;
      tick();
      sync_strobe = 0;
    end
    wt(1'b1, 6);
    chk({13'h0, input_select}, {13'h0, ctl[4:2]});
    chk({12'h0, converter_sync_enable, reference_to_bypass_pin,
      external_reference_select, converter_enable},
      {12'h0, ctl[0], ctl[1], ctl[5], ctl[15]});
    rd(4'hb, {1'b0, res, 5'h00});
    wt(1'b0, 300);
    chk(busy_n[15:0], 16'h00b9);
    chk(hold_n[15:0], 16'h003c);
    res = lv;
    rd(4'hb, {1'b1, lv, 5'h00});
  endtask

  initial begin
    void'($urandom(32'hbb47855d));
    repeat (3) @(posedge mclk);
    #1 rstn = 1;
    rd(4'ha, 16'h0000);
    rd(4'hb, 16'h0000);
    rd(4'hc, {VEN, DEV, VER});
    rd(4'h9, 16'h0000);
    rd(4'h3, 16'h0000);
    for (i = 0; i < 4; i++) begin
      w = $urandom;
      w[9:8] = i[1:0];
      wr(4'h9, w);
      tick();
      chk({12'h0, plus_y_power, minus_y_power, plus_x_power,
        minus_x_power}, {12'h0, w[3:0] & ~w[7:4]});
      chk({13'h0, touch_interrupt_mode, touch_pressure_mode,
        touch_position_mode}, {13'h0, i == 0, i == 1, w[9]});
      rd(4'h9, w & 16'h0bff);
    end
    pen_down = 1;
    repeat (4) tick();
    rd(4'h9, (w & 16'h0bff) | 16'h3000);
    pen_down = 0;
    for (i = 0; i < 8; i++)
      conv(16'h8000 | (i << 2) | (i & 1) | ($urandom & 16'h0022),
        $urandom);
    wr(4'ha, 16'h8080);
    repeat (5) tick();
    chk({15'h0, conversion_busy}, 16'h0000);
    rd(4'ha, 16'h8080);
    wr(4'ha, 16'h0000);
    wr(4'ha, 16'h0080);
    repeat (5) tick();
    chk({15'h0, conversion_busy}, 16'h0000);
    wr(4'ha, 16'h8000);
    wr(4'ha, 16'h8080);
    wt(1'b1, 6);
    wr(4'ha, 16'h0000);
    wt(1'b0, 4);
    rd(4'hb, {1'b0, res, 5'h00});
    test_done();
  end
endmodule // tb_top
